// file: adcs_regs.vh
// Register offsets, field positions and timing constants of the conversion sequencer
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH
// Register byte offsets
`define ADCS_OFF_CTRL_A   8'h00
`define ADCS_OFF_CTRL_B   8'h04
`define ADCS_OFF_CFG1     8'h08
`define ADCS_OFF_CFG2     8'h0c
`define ADCS_OFF_CV1      8'h10
`define ADCS_OFF_CV2      8'h14
`define ADCS_OFF_RESA_HI  8'h18
`define ADCS_OFF_RESA_LO  8'h1c
`define ADCS_OFF_RESB_HI  8'h20
`define ADCS_OFF_RESB_LO  8'h24
`define ADCS_OFF_STATUS   8'h28
`define ADCS_OFF_CTIME    8'h2c
// Control set fields
`define ADCS_CH_OFF       5'h1f
`define ADCS_CTRL_DIFF    5
`define ADCS_CTRL_IE      6
`define ADCS_CTRL_DONE    7
// First config register fields
`define ADCS_CFG1_DIV_LO  0
`define ADCS_CFG1_LSMP    2
`define ADCS_CFG1_MODE_LO 3
`define ADCS_CFG1_LPC     5
`define ADCS_CFG1_ACKEN   6
`define ADCS_CFG1_CLK_LO  7
// Second config register fields
`define ADCS_CFG2_TRG     0
`define ADCS_CFG2_CONT    1
`define ADCS_CFG2_AVG_EN  2
`define ADCS_CFG2_AVG_N_LO 3
`define ADCS_CFG2_CMPE    5
`define ADCS_CFG2_CMPGT   6
`define ADCS_CFG2_CMPRE   7
`define ADCS_CFG2_HSC     8
`define ADCS_CFG2_LSTS_LO 9
// Timing figures
`define ADCS_CLK_NS       10
`define ADCS_WARM_NS      5000
// Warm-up of 5000 ns counted in 10 ns bus cycles
`define ADCS_WARM_CYC     10'h1f4
`define ADCS_BUS_ADDER    10'h005
`define ADCS_SFC_LONG     3
`define ADCS_SFC_SHORT    5
`define ADCS_HSC_ADDER    4
`define ADCS_SHORT_SAMPLE 4
`endif

// file: adcs_seq.v
// Conversion sequencer of a successive-approximation converter with APB registers
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.vh"

// Operation
// - Primary control write starts software conversion
// - Hardware trigger starts conversion on selected set
// - Continuous mode restarts after each transfer
// - Averaging repeats conversions until count reached
// - Done flag sets on transfer only
// - Interrupt when done set and enabled
// - Half-read result blocks new transfer
// - Blocked transfer restarts conversion except noted
// - Owning control write aborts, primary restarts
// - Other register writes abort conversion
// - Reset, deep stop entry, or intermediate stop entry without async clock aborts conversion
// - Abort keeps results; deep stop clears
// - Async clock idles unless enabled or converting on it
// - Total time formula computed
// - First conversion adder by sample length
// - Averaging factor one or 4..32
// - Base time per resolution mode
// - Long sample adder by length code
// - High speed adds four cycles
// - Sample, isolate, approximate, transfer
// - Averaging status while averaging runs
// - Six compare modes
module adcs_seq #(
	parameter [7:0] ASYNC_DIV = 8'h03 // Async generator period in pclk cycles
) (
	// Clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Trigger pins and analog front end
	input  wire        hw_conv_trigger,
	input  wire        hw_trigger_primary_select,
	input  wire        hw_trigger_set_select,
	input  wire [15:0] sar_code,
	// Power modes from the system
	input  wire        deepest_stop_mode,
	input  wire        intermediate_stop_mode,
	// Status and front end control
	output reg         irq,
	output reg         conversion_active_status,
	output reg         average_active,
	output reg         sample_enable,
	output reg  [4:0]  channel_out,
	output reg         diff_out,
	output reg         async_clk_run
);
	// State codes
	localparam [1:0] ST_IDLE = 2'h0, ST_FIRST = 2'h1, ST_CONV = 2'h2, ST_DONE = 2'h3;

	// =====================================================
	// Timing functions
	// Base conversion time by mode and polarity
	function [5:0] base_conv_time;
		input [1:0] mode;
		input       dif;
		begin
			case (mode)
				2'h0:    base_conv_time = dif ? 6'h1b : 6'h11;
				2'h3:    base_conv_time = dif ? 6'h22 : 6'h19;
				default: base_conv_time = dif ? 6'h1e : 6'h14;
			endcase
		end
	endfunction
	// Long sample adder by length code
	function [4:0] long_sample_adder;
		input       en;
		input [1:0] len;
		begin
			case ({en, len})
				3'h4:    long_sample_adder = 5'h14;
				3'h5:    long_sample_adder = 5'h0c;
				3'h6:    long_sample_adder = 5'h06;
				3'h7:    long_sample_adder = 5'h02;
				default: long_sample_adder = 5'h00;
			endcase
		end
	endfunction

	// =====================================================
	// Registers and state
	reg  [7:0]  ctrl_a_reg, ctrl_b_reg;   // Control sets, bit 7 is done
	reg  [7:0]  cfg1_reg;                 // Clock, sample, mode config
	reg  [10:0] cfg2_reg;                 // Trigger, modes, compare config
	reg  [15:0] cv1_reg, cv2_reg;         // Compare values
	reg  [15:0] res_a_reg, res_b_reg;     // Result pairs
	reg  [1:0]  hi_read_reg;              // High byte read, low pending
	reg  [1:0]  state_reg;                // Engine state
	reg         set_reg;                  // Launching set, 1 is set B
	reg  [9:0]  bus_cnt_reg;              // Bus cycle part of first adder
	reg  [5:0]  cnt_reg;                  // Conversion clock tick count
	reg  [5:0]  avg_cnt_reg;              // Conversions done in set
	reg  [20:0] acc_reg;                  // Averaging accumulator
	reg  [7:0]  tdiv_reg;                 // Conversion clock divider
	reg  [2:0]  trg_s1, trg_s2;           // Pin synchronisers
	reg         trg_d;                    // Trigger edge history
	reg  [15:0] code_s1, code_s2;         // Analog code synchroniser
	reg         deep_stop_d, mid_stop_d;  // Stop mode edge history
	reg  [11:0] ctime_reg;                // Total conversion time

	// Config field views
	wire [1:0] clk_div  = cfg1_reg[`ADCS_CFG1_DIV_LO +: 2];
	wire       lsmp     = cfg1_reg[`ADCS_CFG1_LSMP];
	wire [1:0] mode     = cfg1_reg[`ADCS_CFG1_MODE_LO +: 2];
	wire       ack_en   = cfg1_reg[`ADCS_CFG1_ACKEN];
	wire       sel_as   = cfg1_reg[`ADCS_CFG1_CLK_LO];
	wire       hw_trg   = cfg2_reg[`ADCS_CFG2_TRG];
	wire       cont     = cfg2_reg[`ADCS_CFG2_CONT];
	wire       avg_en   = cfg2_reg[`ADCS_CFG2_AVG_EN];
	wire [1:0] avg_sel  = cfg2_reg[`ADCS_CFG2_AVG_N_LO +: 2];
	wire       cmpe     = cfg2_reg[`ADCS_CFG2_CMPE];
	wire       cmpgt    = cfg2_reg[`ADCS_CFG2_CMPGT];
	wire       cmpre    = cfg2_reg[`ADCS_CFG2_CMPRE];
	wire       hsc      = cfg2_reg[`ADCS_CFG2_HSC];
	wire [1:0] lsts     = cfg2_reg[`ADCS_CFG2_LSTS_LO +: 2];
	wire [7:0] act_ctrl = set_reg ? ctrl_b_reg : ctrl_a_reg;

	// =====================================================
	// APB decode
	wire acc  = psel & penable & pready;
	wire wr   = acc & pwrite;
	wire rd   = acc & ~pwrite;
	wire busy = (state_reg != ST_IDLE);
	wire wr_a = wr & (paddr == `ADCS_OFF_CTRL_A);
	wire wr_b = wr & (paddr == `ADCS_OFF_CTRL_B);

	// Timing: factor, base, adders
	// Averaging factor select
	wire [5:0]  avg_n    = avg_en ? (6'h04 << avg_sel) : 6'h01;
	wire [6:0]  conv_len = {1'b0, base_conv_time(mode, act_ctrl[`ADCS_CTRL_DIFF])} +
	                       {2'h0, long_sample_adder(lsmp, lsts)} + (hsc ? 7'h04 : 7'h00);
	wire [2:0]  sfc_adck = lsmp ? 3'h3 : 3'h5;
	// Total time for primary set, ADCK cycles
	wire [6:0]  len_a    = {1'b0, base_conv_time(mode, ctrl_a_reg[`ADCS_CTRL_DIFF])} +
	                       {2'h0, long_sample_adder(lsmp, lsts)} + (hsc ? 7'h04 : 7'h00);
	wire [12:0] prod     = avg_n * len_a;
	wire [11:0] ctime    = prod[11:0] + {9'h000, sfc_adck};

	// Conversion clock tick: source period shifted by divide select
	wire [7:0] base_per = sel_as ? ASYNC_DIV : (cfg1_reg[`ADCS_CFG1_CLK_LO - 1] ? 8'h01 : 8'h02);
	// Low-power bit is stored only and does not slow the clock
	wire [7:0] per      = base_per << clk_div;
	// Async generator runs if enabled or converting on the async clock
	wire gen_run = ack_en | (sel_as & busy);
	wire tick    = busy & (tdiv_reg == per - 8'h01) & (~sel_as | gen_run);

	// Trigger edge and selects from synchronised pins
	wire trg_rise = trg_s2[0] & ~trg_d;
	wire sel_pa   = trg_s2[1];
	wire sel_pb   = trg_s2[2];

	wire sw_start = wr_a & ~hw_trg & (pwdata[4:0] != `ADCS_CH_OFF);
	// Hardware start, select picks set, none is off
	wire hw_set   = sel_pb & ~sel_pa;
	wire [4:0] hw_ch = hw_set ? ctrl_b_reg[4:0] : ctrl_a_reg[4:0];
	wire hw_start = hw_trg & trg_rise & ~busy & (sel_pa | sel_pb) & (hw_ch != `ADCS_CH_OFF);

	// Abort causes
	// Write to owning control set
	wire ab_own  = busy & ((wr_a & ~set_reg) | (wr_b & set_reg));
	wire ab_oth  = busy & wr & ~(paddr == `ADCS_OFF_CTRL_A) & ~(paddr == `ADCS_OFF_CTRL_B);
	// Stop entry aborts; intermediate only without async clock
	wire deep_stop_e = deepest_stop_mode & ~deep_stop_d;
	wire ab_stop = deep_stop_e | (intermediate_stop_mode & ~mid_stop_d & ~(sel_as & gen_run));
	wire abort   = ab_own | ab_oth | ab_stop;

	// Completion decision
	wire [20:0] avg_sh  = acc_reg >> (avg_en ? ({3'h0, avg_sel} + 5'h02) : 5'h00);
	wire [15:0] result  = avg_sh[15:0];
	wire        lt1     = result < cv1_reg;
	wire        lt2     = result < cv2_reg;
	wire        gt2     = result > cv2_reg;
	wire        ord     = cv1_reg <= cv2_reg;
	wire        cmp_ok  = ~cmpre ? (cmpgt ? ~lt1 : lt1) :
	                      (cmpgt ? (ord ? (~lt1 & ~gt2) : (~lt1 | ~gt2)) :
	                               (ord ? (lt1 | gt2) : (lt1 & gt2)));
	wire        last    = ({1'b0, avg_cnt_reg} + 7'h01) >= {1'b0, avg_n};
	wire        eight   = (mode == 2'h0) & ~act_ctrl[`ADCS_CTRL_DIFF];
	wire        blocked = hi_read_reg[set_reg] & ~eight;
	wire        cmp_f   = cmpe & ~cmp_ok;
	// Transfer only on last conversion and true compare
	wire        xfer    = (state_reg == ST_DONE) & ~abort & last & ~cmp_f & ~blocked;
	wire        again   = (state_reg == ST_DONE) & last & (cmp_f ? cont : (blocked | cont));

	// =====================================================
	// APB registers and read side effects
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_reg  <= 8'h1f;
			ctrl_b_reg  <= 8'h1f;
			cfg1_reg    <= 8'h00;
			cfg2_reg    <= 11'h000;
			cv1_reg     <= 16'h0000;
			cv2_reg     <= 16'h0000;
			res_a_reg   <= 16'h0000;
			res_b_reg   <= 16'h0000;
			hi_read_reg <= 2'h0;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			prdata      <= 32'h0000_0000;
		end else if (ce) begin
			// Zero-wait answer: ready in the first access cycle
			pready <= psel & ~penable & ~pready;
			// Config and compare writes
			if (wr && paddr == `ADCS_OFF_CFG1) cfg1_reg <= pwdata[7:0];
			if (wr && paddr == `ADCS_OFF_CFG2) cfg2_reg <= pwdata[10:0];
			if (wr && paddr == `ADCS_OFF_CV1) cv1_reg <= pwdata[15:0];
			if (wr && paddr == `ADCS_OFF_CV2) cv2_reg <= pwdata[15:0];
			// Control writes keep done, low-byte read clears it; set wins
			if (wr_a) ctrl_a_reg[6:0] <= pwdata[6:0];
			if (wr_b) ctrl_b_reg[6:0] <= pwdata[6:0];
			if (rd && paddr == `ADCS_OFF_RESA_LO) ctrl_a_reg[`ADCS_CTRL_DONE] <= 1'b0;
			if (rd && paddr == `ADCS_OFF_RESB_LO) ctrl_b_reg[`ADCS_CTRL_DONE] <= 1'b0;
			// Half-read tracking per pair
			if (rd && paddr == `ADCS_OFF_RESA_HI) hi_read_reg[0] <= 1'b1;
			if (rd && paddr == `ADCS_OFF_RESA_LO) hi_read_reg[0] <= 1'b0;
			if (rd && paddr == `ADCS_OFF_RESB_HI) hi_read_reg[1] <= 1'b1;
			if (rd && paddr == `ADCS_OFF_RESB_LO) hi_read_reg[1] <= 1'b0;
			// Transfer into launching set, flag set
			if (xfer && !set_reg) begin
				res_a_reg <= result;
				ctrl_a_reg[`ADCS_CTRL_DONE] <= 1'b1;
			end
			if (xfer && set_reg) begin
				res_b_reg <= result;
				ctrl_b_reg[`ADCS_CTRL_DONE] <= 1'b1;
			end
			if (deep_stop_e) begin
				res_a_reg <= 16'h0000;
				res_b_reg <= 16'h0000;
			end
			// Read data captured in setup cycle
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`ADCS_OFF_CTRL_A:  prdata <= {24'h0, ctrl_a_reg};
					`ADCS_OFF_CTRL_B:  prdata <= {24'h0, ctrl_b_reg};
					`ADCS_OFF_CFG1:    prdata <= {24'h0, cfg1_reg};
					`ADCS_OFF_CFG2:    prdata <= {21'h0, cfg2_reg};
					`ADCS_OFF_CV1:     prdata <= {16'h0, cv1_reg};
					`ADCS_OFF_CV2:     prdata <= {16'h0, cv2_reg};
					`ADCS_OFF_RESA_HI: prdata <= {24'h0, res_a_reg[15:8]};
					`ADCS_OFF_RESA_LO: prdata <= {24'h0, res_a_reg[7:0]};
					`ADCS_OFF_RESB_HI: prdata <= {24'h0, res_b_reg[15:8]};
					`ADCS_OFF_RESB_LO: prdata <= {24'h0, res_b_reg[7:0]};
					`ADCS_OFF_STATUS:  prdata <= {27'h0, gen_run, avg_en & busy, set_reg, busy, 1'b0};
					`ADCS_OFF_CTIME:   prdata <= {20'h0, ctime_reg};
					default:           prdata <= 32'h0000_0000;
				endcase
			end
			// Unmapped offsets answer with an error
			if (psel && !penable)
				pslverr <= (paddr > `ADCS_OFF_CTIME) | (paddr[1:0] != 2'h0);
			else
				pslverr <= 1'b0;
		end
	end

	// =====================================================
	// Synchronisers and edge history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trg_s1  <= 3'h0;
			trg_s2  <= 3'h0;
			trg_d   <= 1'b0;
			code_s1 <= 16'h0000;
			code_s2 <= 16'h0000;
			deep_stop_d <= 1'b0;
			mid_stop_d  <= 1'b0;
		end else if (ce) begin
			trg_s1  <= {hw_trigger_set_select, hw_trigger_primary_select, hw_conv_trigger};
			trg_s2  <= trg_s1;
			trg_d   <= trg_s2[0];
			code_s1 <= sar_code;
			code_s2 <= code_s1;
			deep_stop_d <= deepest_stop_mode;
			mid_stop_d  <= intermediate_stop_mode;
		end
	end

	// =====================================================
	// Conversion engine
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			set_reg     <= 1'b0;
			bus_cnt_reg <= 10'h000;
			cnt_reg     <= 6'h00;
			avg_cnt_reg <= 6'h00;
			acc_reg     <= 21'h000000;
			tdiv_reg    <= 8'h00;
		end else if (ce) begin
			// Conversion clock divider, restarts when idle
			if (!busy || tick)
				tdiv_reg <= 8'h00;
			else
				tdiv_reg <= tdiv_reg + 8'h01;
			if (sw_start || hw_start) begin
				set_reg     <= sw_start ? 1'b0 : hw_set;
				state_reg   <= ST_FIRST;
				cnt_reg     <= 6'h00;
				avg_cnt_reg <= 6'h00;
				acc_reg     <= 21'h000000;
				// Bus cycles, plus warm-up on cold async clock
				bus_cnt_reg <= (sel_as & ~ack_en) ? `ADCS_WARM_CYC + `ADCS_BUS_ADDER :
				                                    `ADCS_BUS_ADDER;
			end else if (abort) begin
				state_reg <= ST_IDLE;
			end else begin
				case (state_reg)
					ST_FIRST: begin
						if (bus_cnt_reg != 10'h000)
							bus_cnt_reg <= bus_cnt_reg - 10'h001;
						else if (tick && cnt_reg == {3'h0, sfc_adck} - 6'h01) begin
							cnt_reg   <= 6'h00;
							state_reg <= ST_CONV;
						end else if (tick)
							cnt_reg <= cnt_reg + 6'h01;
					end
					ST_CONV: begin
						if (tick && cnt_reg == conv_len[5:0] - 6'h01) begin
							acc_reg   <= acc_reg + {5'h00, code_s2};
							cnt_reg   <= 6'h00;
							state_reg <= ST_DONE;
						end else if (tick)
							cnt_reg <= cnt_reg + 6'h01;
					end
					ST_DONE: begin
						if (!last) begin
							avg_cnt_reg <= avg_cnt_reg + 6'h01;
							state_reg   <= ST_CONV;
						end else if (again) begin
							avg_cnt_reg <= 6'h00;
							acc_reg     <= 21'h000000;
							state_reg   <= ST_CONV;
						end else
							state_reg <= ST_IDLE;
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// =====================================================
	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq                      <= 1'b0;
			conversion_active_status <= 1'b0;
			average_active           <= 1'b0;
			sample_enable            <= 1'b0;
			channel_out              <= 5'h1f;
			diff_out                 <= 1'b0;
			async_clk_run            <= 1'b0;
			ctime_reg                <= 12'h000;
		end else if (ce) begin
			irq <= (ctrl_a_reg[`ADCS_CTRL_DONE] & ctrl_a_reg[`ADCS_CTRL_IE]) |
			       (ctrl_b_reg[`ADCS_CTRL_DONE] & ctrl_b_reg[`ADCS_CTRL_IE]);
			conversion_active_status <= busy;
			average_active <= busy & avg_en;
			// Track input, isolate after sample window
			sample_enable <= (state_reg == ST_CONV) &&
			                 ({1'b0, cnt_reg} < {2'h0, long_sample_adder(lsmp, lsts)} + 7'h04);
			channel_out   <= busy ? act_ctrl[4:0] : `ADCS_CH_OFF;
			diff_out      <= busy & act_ctrl[`ADCS_CTRL_DIFF];
			async_clk_run <= gen_run;
			// Total time in conversion clock cycles
			ctime_reg     <= ctime;
		end
	end
endmodule // adcs_seq
`default_nettype wire

// file: adcs_front_model.sv
// Analog channel and trigger source model of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_front_model (
	// Clock
	input  wire logic        pclk,
	// Bench controls
	input  wire logic [15:0] level,
	input  wire logic        fire,
	input  wire logic        sel_b,
	// Converter side
	output logic      [15:0] sar_code,
	output logic             hw_conv_trigger,
	output logic             hw_trigger_primary_select,
	output logic             hw_trigger_set_select
);
	logic [2:0] cnt_reg = 3'h0; // Trigger pulse length left
	// Analog level passed straight through from the bench
	assign sar_code = level;
	assign hw_trigger_primary_select = !sel_b;
	assign hw_trigger_set_select     = sel_b;
	always @(posedge pclk) begin
		if (fire) begin
			cnt_reg <= 3'h4;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end
	assign hw_conv_trigger = (cnt_reg != 3'h0);
endmodule // adcs_front_model
`default_nettype wire

// file: adcs_seq_props.sv
// Port checker of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.vh"
module adcs_seq_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Status
	input wire logic        irq,
	input wire logic        conversion_active_status,
	input wire logic        average_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr; // Completed write
	logic      trg_reg; // Hardware trigger mode copy
	assign wr = psel && penable && pready && pwrite;
	// Track trigger mode from register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trg_reg <= 1'b0;
		end else if (wr && paddr == `ADCS_OFF_CFG2) begin
			trg_reg <= pwdata[0];
		end
	end
	property p_rdy_once;
		psel && penable && pready |=> !pready;
	endproperty
	a_rdy_once: assert property (p_rdy_once) else $error("pready held too long");
	property p_rdy_setup;
		ce && psel && !penable |=> pready;
	endproperty
	a_rdy_setup: assert property (p_rdy_setup) else $error("pready missing in access");
	property p_err_bad;
		ce && psel && !penable && (paddr > 8'h2c || paddr[1:0] != 2'h0) |=> pslverr && pready;
	endproperty
	a_err_bad: assert property (p_err_bad) else $error("bad address not refused");
	property p_sw_start;
		wr && paddr == `ADCS_OFF_CTRL_A && !trg_reg && pwdata[4:0] != 5'h1f |-> ##[1:3] conversion_active_status;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start lost");
	property p_off_nostart;
		wr && paddr == `ADCS_OFF_CTRL_A && !trg_reg && pwdata[4:0] == 5'h1f && !conversion_active_status
			|=> !conversion_active_status [*3];
	endproperty
	a_off_nostart: assert property (p_off_nostart) else $error("off channel started");
	property p_abort;
		wr && paddr >= 8'h08 && paddr[1:0] == 2'h0 && conversion_active_status |-> ##[1:3] !conversion_active_status;
	endproperty
	a_abort: assert property (p_abort) else $error("register write did not abort");
	property p_irq_fall;
		$fell(irq) |-> $past(psel && penable) || $past(psel && penable, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
	property p_avg;
		average_active |-> ##[0:1] conversion_active_status;
	endproperty
	a_avg: assert property (p_avg) else $error("averaging flag while idle");
	c_done: cover property ($fell(conversion_active_status));
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
endmodule // adcs_seq_props
bind adcs_seq adcs_seq_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.conversion_active_status(conversion_active_status), .average_active(average_active));
`default_nettype wire

// file: adcs_seq_tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.vh"
module adcs_seq_tb;
	// Design inputs
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        deep_stop = 1'b0;
	logic        mid_stop = 1'b0;
	logic [15:0] level = 16'h0;
	logic        fire = 1'b0;
	logic        sel_b = 1'b0;
	// Design outputs and model wires
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, act, avg, trig, sel_a, sel_n, smp, dif, clk_run;
	wire  [15:0] code;
	wire  [4:0]  chan;
	// Bench state
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic        smp_seen = 1'b0;
	logic [31:0] lf = 32'h30df;
	logic [32:0] expq[$];
	adcs_seq u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hw_conv_trigger(trig), .hw_trigger_primary_select(sel_a), .hw_trigger_set_select(sel_n),
		.sar_code(code), .deepest_stop_mode(deep_stop), .intermediate_stop_mode(mid_stop), .irq(irq),
		.conversion_active_status(act), .average_active(avg), .sample_enable(smp), .channel_out(chan),
		.diff_out(dif), .async_clk_run(clk_run));
	adcs_front_model u_front (.pclk(pclk), .level(level), .fire(fire), .sel_b(sel_b), .sar_code(code),
		.hw_conv_trigger(trig), .hw_trigger_primary_select(sel_a), .hw_trigger_set_select(sel_n));
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	// Closing report
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			chk("timeout", 33'h0, 33'h1);
			stop_test();
		end
	end
	// Sample window seen at least once
	always @(posedge pclk) begin
		if (smp === 1'b1) smp_seen <= 1'b1;
	end
	// Read answers against oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (expq.size() == 0) chk("queue", 33'h0, 33'h1);
			else chk("read", expq.pop_front(), {pslverr, prdata});
		end
	end
	// One APB transfer, read answer noted
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		logic rdy;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		if (!w) expq.push_back(e);
		do begin
			@(negedge pclk);
			rdy = pready;
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle, so a following call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask
	// High byte then low byte of one set
	task automatic rd_res(input logic b, input logic [15:0] v);
		rd(b ? `ADCS_OFF_RESB_HI : `ADCS_OFF_RESA_HI, {24'h0, v[15:8]});
		rd(b ? `ADCS_OFF_RESB_LO : `ADCS_OFF_RESA_LO, {24'h0, v[7:0]});
	endtask
	// Bounded wait for the engine to go idle
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		while (act === 1'b1 && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		chk("idle", 33'h0, {32'h0, act});
		@(posedge pclk);
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Expected total time in converter clocks
	function automatic logic [31:0] ctime(input logic [31:0] c1, input logic [31:0] c2, input logic df);
		int b;
		int f;
		int l;
		case (c1[4:3])
			2'h0: b = df ? 27 : 17;
			2'h3: b = df ? 34 : 25;
			default: b = df ? 30 : 20;
		endcase
		f = c2[2] ? (4 << c2[4:3]) : 1;
		l = !c1[2] ? 0 : c2[10:9] == 2'h0 ? 20 : c2[10:9] == 2'h1 ? 12 : c2[10:9] == 2'h2 ? 6 : 2;
		return (c1[2] ? 3 : 5) + f * (b + l + (c2[8] ? 4 : 0));
	endfunction
	// Main sequence
	initial begin
		logic [15:0] old;
		logic [31:0] c1;
		logic [31:0] c2;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and refused addresses
		rd(`ADCS_OFF_CTRL_A, 32'h1f);
		rd(`ADCS_OFF_CTRL_B, 32'h1f);
		rd(`ADCS_OFF_CFG2, 32'h0);
		rd_res(1'b0, 16'h0);
		apb(1'b0, 8'h30, 32'h0, 33'h100000000);
		apb(1'b0, 8'h02, 32'h0, 33'h100000000);
		$display("reset test done");
		repeat (12) begin
			lf = nxt(lf);
			c1 = {24'h0, 2'h1, lf[5:0]};
			c2 = {21'h0, lf[13:11], 3'h0, lf[10:8], 2'h0};
			wr(`ADCS_OFF_CTRL_A, {26'h0, lf[20], 5'h1f});
			wr(`ADCS_OFF_CFG1, c1);
			wr(`ADCS_OFF_CFG2, c2);
			rd(`ADCS_OFF_CTIME, ctime(c1, c2, lf[20]));
		end
		$display("timing test done");
		lf = nxt(lf);
		level <= lf[15:0];
		wr(`ADCS_OFF_CFG1, 32'h58);
		wr(`ADCS_OFF_CFG2, 32'h04);
		wr(`ADCS_OFF_CTRL_A, 32'h43);
		repeat (4) @(posedge pclk);
		chk("avg", 33'h1, {32'h0, avg});
		wait_idle();
		chk("irq", 33'h1, {32'h0, irq});
		chk("sample", 33'h1, {32'h0, smp_seen});
		rd(`ADCS_OFF_CTRL_A, 32'hc3);
		rd_res(1'b0, level);
		repeat (2) @(posedge pclk);
		chk("irq", 33'h0, {32'h0, irq});
		$display("average test done");
		// False compare ends a single conversion
		old = level;
		wr(`ADCS_OFF_CV1, 32'hffff);
		wr(`ADCS_OFF_CFG2, 32'h60);
		level <= {old[15:1] ^ 15'h1, 1'b0};
		wr(`ADCS_OFF_CTRL_A, 32'h03);
		wait_idle();
		rd(`ADCS_OFF_CTRL_A, 32'h03);
		rd_res(1'b0, old);
		$display("compare test done");
		wr(`ADCS_OFF_CFG2, 32'h0);
		rd(`ADCS_OFF_RESA_HI, {24'h0, old[15:8]});
		lf = nxt(lf);
		level <= lf[15:0];
		wr(`ADCS_OFF_CTRL_A, 32'h03);
		repeat (300) @(posedge pclk);
		rd(`ADCS_OFF_CTRL_A, 32'h03);
		rd(`ADCS_OFF_RESA_LO, {24'h0, old[7:0]});
		wait_idle();
		rd(`ADCS_OFF_CTRL_A, 32'h83);
		rd_res(1'b0, level);
		old = level;
		$display("blocking test done");
		// Hardware trigger on the second set
		wr(`ADCS_OFF_CFG2, 32'h01);
		wr(`ADCS_OFF_CTRL_B, 32'h05);
		sel_b <= 1'b1;
		level <= ~old;
		repeat (8) @(posedge pclk);
		chk("active", 33'h0, {32'h0, act});
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("channel", 33'h5, {28'h0, chan});
		chk("diff", 33'h0, {32'h0, dif});
		chk("clkrun", 33'h1, {32'h0, clk_run});
		wait_idle();
		rd(`ADCS_OFF_CTRL_B, 32'h85);
		rd_res(1'b1, ~old);
		rd(`ADCS_OFF_CTRL_A, 32'h03);
		$display("trigger test done");
		// Aborts by write and by deep stop, none by intermediate stop on async clock
		wr(`ADCS_OFF_CFG2, 32'h0);
		for (int k = 0; k < 3; k++) begin
			level <= old ^ 16'h5a5a;
			// Async clock enabled well before the start
			if (k == 2) begin
				wr(`ADCS_OFF_CFG1, 32'hc0);
				repeat (`ADCS_WARM_CYC) @(posedge pclk);
			end
			wr(`ADCS_OFF_CTRL_A, 32'h03);
			repeat (10) @(posedge pclk);
			if (k == 0) wr(`ADCS_OFF_CV2, 32'h0);
			else if (k == 1) deep_stop <= 1'b1;
			else mid_stop <= 1'b1;
			wait_idle();
			deep_stop <= 1'b0;
			mid_stop <= 1'b0;
			rd_res(1'b0, k == 0 ? old : k == 1 ? 16'h0 : old ^ 16'h5a5a);
		end
		rd_res(1'b1, 16'h0);
		$display("abort test done");
		stop_test();
	end
endmodule // adcs_seq_tb
`default_nettype wire
